// file: settle_timer.v
// Purpose: settling-time counter for the tuning engine
// Assumes: start is a one-cycle pulse on clk
// Notes: wait length = base_cycles << sel
`timescale 1ns/1ps
`include "vco_tune_defines.vh"

module settle_timer #(
    parameter BASE_CYCLES = `SETTLE_BASE_CYC,
    parameter CW = 16
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // control
    input wire start,
    input wire abort,
    input wire [2:0] sel,
    // status
    output wire expired
);
    reg [CW-1:0] count_r;
    reg running_r;
    wire [CW-1:0] base_w = BASE_CYCLES[CW-1:0];

    // load on start, count down to one; abort drops a pending wait
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            count_r <= {CW{1'b0}};
            running_r <= 1'b0;
        end else if (abort) begin
            count_r <= {CW{1'b0}};
            running_r <= 1'b0;
        end else if (start) begin
            count_r <= base_w << sel;
            running_r <= 1'b1;
        end else if (running_r) begin
            count_r <= count_r - {{(CW-1){1'b0}}, 1'b1};
            if (count_r == {{(CW-1){1'b0}}, 1'b1})
                running_r <= 1'b0;
        end
    end

    assign expired = running_r && (count_r == {{(CW-1){1'b0}}, 1'b1});
endmodule // settle_timer

// file: synth_vco_tune_sequencer.v
// Purpose: control and status of the oscillator tuning engine
// Assumes: one clock; register port and comparator are same-domain logic
// Notes: trim search is a 7-bit successive approximation driven by
//   freq_high from the synthesizer frequency comparator
`timescale 1ns/1ps
`include "vco_tune_defines.vh"

module synth_vco_tune_sequencer #(
    parameter BASE_CYCLES = `SETTLE_BASE_CYC
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // synthesizer side
    input wire freq_high,
    output wire [6:0] osc_trim_code,
    output wire synth_cal_hold,
    output wire tune_busy
);
    localparam S_IDLE = 2'd0;
    localparam S_SETTLE = 2'd1;
    localparam S_DONE = 2'd2;

    reg [7:0] trim_r;
    reg hold_r;
    reg [7:0] ctrl_r;
    reg done_r;
    reg [1:0] state_r;
    reg [6:0] bit_r;
    reg hold_d_r;
    wire settle_done;
    wire hold_fall = hold_d_r && !hold_r;
    wire tune_engine_enable = ctrl_r[`ENABLE_BIT];
    wire [2:0] tune_settle_select = ctrl_r[`SETTLE_MSB:`SETTLE_LSB];
    wire start_settle;
    wire abort_settle = hold_r;

    function sel_hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            sel_hit = (a == ofs);
        end
    endfunction

    // hold bit write and its delayed copy for release detection
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_r <= 1'b0;
            hold_d_r <= 1'b0;
            ctrl_r <= `RST_TUNE_ENGINE_CONTROL;
        end else begin
            hold_d_r <= hold_r;
            if (reg_wr && sel_hit(reg_addr, `OFS_SYNTH_CAL_HOLD))
                hold_r <= reg_wdata[`HOLD_BIT];
            // control writes accepted anytime; software keeps hold at 1
            if (reg_wr && sel_hit(reg_addr, `OFS_TUNE_ENGINE_CONTROL))
                ctrl_r <= reg_wdata;
        end
    end

    assign start_settle = (state_r == S_IDLE) && hold_fall &&
        tune_engine_enable;

    // tuning sequence: binary search from msb to lsb, one settle per step
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= S_IDLE;
            trim_r <= `RST_OSC_TRIM_CODE;
            bit_r <= 7'h00;
            done_r <= 1'b0;
        end else begin
            // software trim write; ignored while the engine owns the code
            if (reg_wr && sel_hit(reg_addr, `OFS_OSC_TRIM_CODE) &&
                state_r != S_SETTLE)
                trim_r <= reg_wdata;
            case (state_r)
                S_IDLE: begin
                    if (hold_fall) begin
                        if (tune_engine_enable) begin
                            state_r <= S_SETTLE;
                            bit_r <= 7'h40;
                            trim_r <= {1'b0, 7'h40};
                        end else begin
                            state_r <= S_DONE;
                            done_r <= 1'b1;
                        end
                    end
                end
                S_SETTLE: begin
                    if (!hold_r && settle_done) begin
                        // too fast clears the trial bit, else keep it
                        if (freq_high)
                            trim_r[6:0] <= (trim_r[6:0] & ~bit_r) |
                                (bit_r >> 1);
                        else
                            trim_r[6:0] <= trim_r[6:0] | (bit_r >> 1);
                        if (bit_r == 7'h01) begin
                            if (freq_high)
                                trim_r[6:0] <= trim_r[6:0] & ~bit_r;
                            else
                                trim_r[6:0] <= trim_r[6:0];
                            state_r <= S_DONE;
                            done_r <= 1'b1;
                        end
                        bit_r <= bit_r >> 1;
                    end
                end
                S_DONE: begin
                    state_r <= S_DONE;
                end
                default: state_r <= S_IDLE;
            endcase
            // hold comes last so it also pulls the engine out of S_DONE;
            // otherwise a second release could never start a fresh run
            if (hold_r) begin
                state_r <= S_IDLE;
                done_r <= 1'b0;
            end
        end
    end

    // restart the settle wait after each trim step except the last one, at bit_r == 7'h01
    settle_timer #(
        .BASE_CYCLES(BASE_CYCLES)
    ) u_settle (
        .clk(clk),
        .reset(reset),
        .start(start_settle ||
            (state_r == S_SETTLE && settle_done && bit_r != 7'h01 && !hold_r)),
        .abort(abort_settle),
        .sel(tune_settle_select),
        .expired(settle_done)
    );

    // read mux; reserved status bits read zero
    always @* begin
        reg_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `OFS_OSC_TRIM_CODE: reg_rdata = trim_r;
                `OFS_SYNTH_CAL_HOLD: reg_rdata = {7'h00, hold_r};
                `OFS_TUNE_ENGINE_CONTROL: reg_rdata = ctrl_r;
                `OFS_TUNE_ENGINE_STATUS: reg_rdata = {7'h00, done_r};
                default: reg_rdata = 8'h00;
            endcase
        end
    end

    assign osc_trim_code = trim_r[`TRIM_MSB:0];
    assign synth_cal_hold = hold_r;
    assign tune_busy = (state_r == S_SETTLE);
endmodule // synth_vco_tune_sequencer

// file: synth_vco_tune_sequencer_bench.sv
// Purpose: self-checking bench for the tuning sequencer
// Assumes: comparator is modelled as trim above a target
// Notes: settle base cut to 2 cycles to keep runs short
`timescale 1ns/1ps
`define check(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
    num_errors = num_errors + 1; \
    $display("MISMATCH %0t %h %h", $time, g, e); end end
module synth_vco_tune_sequencer_bench;
    localparam B = 2;
    reg clk = 1'b0;
    reg reset = 1'b1;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg [6:0] tgt = 7'h00;
    reg [7:0] d;
    reg [23:0] rows [0:5];
    wire [7:0] reg_rdata;
    wire [6:0] osc_trim_code;
    wire synth_cal_hold;
    wire tune_busy;
    wire freq_high = osc_trim_code > tgt;
    integer num_errors = 0;
    integer n_tests = 0;
    integer i;
    integer n;
    synth_vco_tune_sequencer #(.BASE_CYCLES(B)) dut (.*);
    always #10 clk = ~clk;
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge clk);
            #1 reg_wr = 1'b1;
            reg_addr = a;
            reg_wdata = v;
            @(posedge clk);
            #1 reg_wr = 1'b0;
        end
    endtask
    // read data is combinational; taken at the edge that ends the request
    task rd(input [7:0] a);
        begin
            @(posedge clk);
            #1 reg_rd = 1'b1;
            reg_addr = a;
            @(posedge clk);
            d = reg_rdata;
            #1 reg_rd = 1'b0;
        end
    endtask
    // one tuning pass; skip passes must leave the trim untouched
    task run(input [7:0] c, input [6:0] t);
        begin
            tgt = t;
            wr(8'h5C, 8'h01);
            wr(8'h5D, c);
            wr(8'h5C, 8'h00);
            n = 0;
            for (i = 0; i < 2200 && !(n > 0 && !tune_busy); i = i + 1) begin
                @(negedge clk);
                n = n + tune_busy;
            end
            `check(c[0] ? n >= 7 * (B << c[6:4]) : n == 0, 1'b1)
            rd(8'h59);
            `check(d, {1'b0, t})
            rd(8'h5E);
            `check(d, 8'h01)
        end
    endtask
    task test_done;
        begin
            $display("errors %0d checks %0d", num_errors, n_tests);
            if (num_errors == 0 && n_tests > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // watchdog well beyond the longest settle pass
    initial begin
        #300000;
        num_errors = num_errors + 1;
        test_done;
    end
    initial begin
        rows[0] = 24'h5C0101;
        rows[1] = 24'h595555;
        rows[2] = 24'h5D7171;
        rows[3] = 24'h5D4040;
        rows[4] = 24'h5EFF00;
        rows[5] = 24'hA0FF00;
        repeat (5) @(posedge clk);
        #1 reset = 1'b0;
        for (i = 0; i < 6; i = i + 1) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            `check(d, rows[i][7:0])
        end
        @(posedge clk);
        #1 reset = 1'b1;
        @(posedge clk);
        #1 reset = 1'b0;
        rd(8'h5D);
        `check(d, 8'h40)
        rd(8'h59);
        `check(d, 8'h00)
        run(8'h01, 7'h2B);
        run(8'h71, 7'h7F);
        run(8'h00, 7'h7F);
        wr(8'h5C, 8'h01);
        rd(8'h5E);
        `check(d, 8'h00)
        test_done;
    end
endmodule // synth_vco_tune_sequencer_bench

// file: vco_tune_checker.sv
// Purpose: port assertions for the tuning sequencer
// Assumes: enable bit has no port, so it is shadowed from writes
// Notes: bound to every instance of the sequencer
`timescale 1ns/1ps
module vco_tune_checker #(
    parameter BASE_CYCLES = 8
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // synthesizer side
    input wire freq_high,
    input wire [6:0] osc_trim_code,
    input wire synth_cal_hold,
    input wire tune_busy
);
    reg en_r;
    // shadow of the enable bit as last written
    always @(posedge clk or posedge reset) begin
        if (reset)
            en_r <= 1'b0;
        else if (reg_wr && reg_addr == 8'h5D)
            en_r <= reg_wdata[0];
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    rsv_zero_a: assert property (reg_rd && reg_addr == 8'h5E
        |-> reg_rdata[7:1] == 7'h00) else $error("status reserved set");
    start_busy_a: assert property ($fell(synth_cal_hold) && en_r
        |-> ##[1:2] tune_busy && osc_trim_code == 7'h40) else $error("no start");
    skip_idle_a: assert property ($fell(synth_cal_hold) && !en_r
        |=> !tune_busy [*3]) else $error("busy on skip");
    hold_idle_a: assert property (synth_cal_hold [*2]
        |-> !tune_busy) else $error("busy in hold");
    trim_wr_a: assert property (reg_wr && reg_addr == 8'h59 && synth_cal_hold
        |=> osc_trim_code == $past(reg_wdata[6:0])) else $error("trim write");
    trim_rd_a: assert property (reg_rd && reg_addr == 8'h59 && !tune_busy
        |-> reg_rdata[6:0] == osc_trim_code) else $error("trim read");
    trim_step_a: assert property (tune_busy && $changed(osc_trim_code)
        |=> $stable(osc_trim_code)) else $error("trim not settled");
    done_busy_a: assert property (reg_rd && reg_addr == 8'h5E && tune_busy
        |-> reg_rdata[0] == 1'b0) else $error("done while busy");
endmodule // vco_tune_checker
bind synth_vco_tune_sequencer vco_tune_checker #(
    .BASE_CYCLES(BASE_CYCLES)) chk (.*);

// file: vco_tune_defines.vh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, 50 MHz clock
// Notes: included by the tuning sequencer files
`ifndef VCO_TUNE_DEFINES_VH
`define VCO_TUNE_DEFINES_VH

// register offsets
`define OFS_OSC_TRIM_CODE 8'h59
`define OFS_SYNTH_CAL_HOLD 8'h5C
`define OFS_TUNE_ENGINE_CONTROL 8'h5D
`define OFS_TUNE_ENGINE_STATUS 8'h5E

// reset values
`define RST_OSC_TRIM_CODE 8'h00
`define RST_SYNTH_CAL_HOLD 8'h00
`define RST_TUNE_ENGINE_CONTROL 8'h40
`define RST_TUNE_ENGINE_STATUS 8'h00

// field positions
`define TRIM_MSB 6
`define HOLD_BIT 0
`define ENABLE_BIT 0
`define SETTLE_MSB 6
`define SETTLE_LSB 4
`define DONE_BIT 0

// settle time: base unit in ns, doubled per settle-select step
`define SETTLE_BASE_NS 160
`define CLK_PERIOD_NS 20
`define SETTLE_BASE_CYC ((`SETTLE_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif
